// ===== core/i2cms_defines.svh
// Constants for the two-wire memory and register slave and its bus master.
// Assumes inclusion by bare name from the package and both end modules.
`ifndef I2CMS_DEFINES_SVH
`define I2CMS_DEFINES_SVH

// Slave identifiers in address bits 7 to 4.
`define I2CMS_MEM_ID       4'hA
`define I2CMS_REG_ID       4'hD
// Highest valid register address.
`define I2CMS_REG_MAX      8'h18
// Memory depth in bytes and address width.
`define I2CMS_MEM_DEPTH    32768
`define I2CMS_MEM_AW       15
// Index of the last bit in a byte and the slot after the last bit.
`define I2CMS_LAST_BIT     4'h7
`define I2CMS_ACK_SLOT     4'h8
// Master clock period and SCL quarter period, in ns.
`define I2CMS_CORE_CLK_NS  8
`define I2CMS_SCL_QTR_NS   250
// SCL quarter period in core clock cycles, a least time rounded up.
`define I2CMS_SCL_QTR_CYC  ((`I2CMS_SCL_QTR_NS + `I2CMS_CORE_CLK_NS - 1) / `I2CMS_CORE_CLK_NS)

`endif

// ===== core/i2cms_pkg.sv
// Types shared by both ends of the two-wire memory and register link.
// Assumes the defines header sits in the include path.
`include "i2cms_defines.svh"

package i2cms_pkg;

	// Byte-level commands taken by the bus master.
	typedef enum logic [1:0] {
		I2CMS_OP_START,
		I2CMS_OP_WRITE,
		I2CMS_OP_READ,
		I2CMS_OP_STOP
	} i2cms_op_e;

	// Slave sequencer states.
	typedef enum logic [2:0] {
		DS_IDLE,
		DS_SLAVE,
		DS_ADDR_HI,
		DS_ADDR_LO,
		DS_REG_ADDR,
		DS_WRITE,
		DS_READ
	} i2cms_dst_e;

	// Master sequencer states.
	typedef enum logic [1:0] {
		HS_IDLE,
		HS_START,
		HS_BIT,
		HS_STOP
	} i2cms_hst_e;

endpackage

// ===== core/i2cms_if.sv
// Two-wire bus between the master end and the slave end.
// Assumes open-drain pins with pull-ups; each enable pulls its line low.
`timescale 1ns/100ps

interface i2cms_if;
	logic scl_o;     // Master clock level when driven.
	logic scl_oe;    // Master drives SCL.
	logic m_sda_o;   // Master data level when driven.
	logic m_sda_oe;  // Master drives SDA.
	logic s_sda_o;   // Slave data level when driven.
	logic s_sda_oe;  // Slave drives SDA.
	logic scl;       // Resolved clock line.
	logic sda;       // Resolved data line.

	// Wired-AND resolution with pull-ups.
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

	modport host (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe, input sda);
	modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ===== core/i2cms_dev.sv
// Slave end: memory and register space access over the two-wire bus.
// Assumes link_clk oversamples SCL by at least eight per SCL half period.
`timescale 1ns/100ps
`include "i2cms_defines.svh"

// Summary of operation
// RULE_01: Address LSB zero means write, addresses follow.
// RULE_02: Acknowledge every write byte, unlimited sequential bytes.
// RULE_03: Write address wraps 7FFFh to 0000h.
// RULE_04: No busy time; always acknowledge polls.
// RULE_05: Commit on eighth bit; earlier abort writes nothing.
// RULE_06: Each byte written alone, no page buffer.
// RULE_07: Read address bit one starts data immediately.
// RULE_08: Increment per byte; master ACK fetches next.
// RULE_09: Master ends read with NACK then STOP.
// RULE_10: STOP or START in ninth clock releases.
// RULE_11: Read address wraps 7FFFh to 0000h.
// RULE_12: Repeated START after address keeps address, reads.
// RULE_13: Register write uses one address byte.
// RULE_14: Master should zero top register address bits.
// RULE_15: Register read from current address, auto-increment.
// RULE_16: Memory and register address latches independent.
// RULE_17: Every write carries its address bytes.
// RULE_18: Answer only identifiers 1010b and 1101b.
// RULE_19: Select bits must match select pins.
// RULE_20: Register address above 18h is refused.
// RULE_21: Fifteen-bit address latched, increments before acknowledge.
// RULE_22: After any abort release SDA, await START.
module i2cms_dev
	import i2cms_pkg::*;
(
	// Link clock and its synchronous reset.
	input  wire logic       link_clk,
	input  wire logic       link_rst_n,
	// Two-wire bus.
	i2cms_if.dev            bus,
	// Device select pins.
	input  wire logic [1:0] dev_sel,
	// Register space write port.
	output logic            reg_wr_stb,
	output logic [7:0]      reg_wr_addr,
	output logic [7:0]      reg_wr_data,
	// Register space read port.
	output logic [7:0]      reg_rd_addr,
	input  wire logic [7:0] reg_rd_data
);

	// Pin synchronisers and previous sample for edge detection.
	logic                    scl_m, scl_s, scl_p;  // SCL stages.
	logic                    sda_m, sda_s, sda_p;  // SDA stages.
	logic [1:0]              sel_m, sel_s;         // Select pin stages.
	// Sequencer state.
	i2cms_dst_e              st_q;                 // Current state.
	i2cms_dst_e              nxt_st;               // State after the ack slot.
	logic [3:0]              cnt_q;                // Bits seen in the byte.
	logic                    ack_q;                // In the ninth bit slot.
	logic [7:0]              sh_q;                 // Received byte.
	logic [7:0]              tx_q;                 // Bits left to send.
	logic                    oe_q;                 // Slave pulls SDA low.
	logic                    sda_o_q;              // Driven level, always low.
	logic                    rd_q;                 // Transaction is a read.
	logic                    reg_sp_q;             // Register space selected.
	logic [`I2CMS_MEM_AW-1:0] maddr_q;             // Memory address latch.
	logic [6:0]              ahi_q;                // First memory address byte.
	logic [7:0]              raddr_q;              // Register address latch.
	logic                    wr_stb_q;             // Register write strobe.
	logic [7:0]              wr_addr_q;            // Register write address.
	logic [7:0]              wr_data_q;            // Register write data.
	logic [7:0]              mem [0:`I2CMS_MEM_DEPTH-1]; // Byte array.
	// Decoded conditions.
	logic                    scl_rise, scl_fall;
	logic                    start_det, stop_det;
	logic                    slave_hit, byte_ok;
	logic                    commit;
	logic [7:0]              wdat;
	logic [7:0]              rd_byte;

	// Bus line edges and the START and STOP conditions.
	assign scl_rise  = scl_s && !scl_p;
	assign scl_fall  = !scl_s && scl_p;
	assign start_det = scl_s && scl_p && sda_p && !sda_s;
	assign stop_det  = scl_s && scl_p && !sda_p && sda_s;

	// Identifier and select match on the received address byte.
	assign slave_hit = ((sh_q[7:4] == `I2CMS_MEM_ID) || (sh_q[7:4] == `I2CMS_REG_ID)) // [RULE_18]
		&& (sh_q[2:1] == sel_s); // [RULE_19]

	// Byte as it stands with the bit being sampled now.
	assign wdat = {sh_q[6:0], sda_s};

	// The eighth data bit of a write byte commits it at once.
	assign commit = (st_q == DS_WRITE) && !ack_q && scl_rise
		&& (cnt_q == `I2CMS_LAST_BIT); // [RULE_05] [RULE_06]

	// Read data comes from the space the identifier chose.
	assign rd_byte = reg_sp_q ? reg_rd_data : mem[maddr_q]; // [RULE_15]

	// Acknowledge decision for a fully received byte.
	always_comb begin
		case (st_q)
			DS_SLAVE:    byte_ok = slave_hit; // [RULE_04]
			DS_REG_ADDR: byte_ok = (sh_q <= `I2CMS_REG_MAX); // [RULE_20]
			default:     byte_ok = 1'b1; // [RULE_02]
		endcase
	end

	// State entered when the acknowledge slot ends.
	always_comb begin
		case (st_q)
			DS_SLAVE: begin
				if (rd_q) begin
					nxt_st = DS_READ; // [RULE_07]
				end else if (reg_sp_q) begin
					nxt_st = DS_REG_ADDR; // [RULE_13]
				end else begin
					nxt_st = DS_ADDR_HI; // [RULE_01]
				end
			end
			DS_ADDR_HI:  nxt_st = DS_ADDR_LO;
			DS_ADDR_LO:  nxt_st = DS_WRITE;
			DS_REG_ADDR: nxt_st = DS_WRITE;
			DS_WRITE:    nxt_st = DS_WRITE;
			default:     nxt_st = DS_IDLE;
		endcase
	end

	// Two flip-flops on every pin before any logic looks at it.
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			{scl_m, scl_s, scl_p} <= 3'h7;
			{sda_m, sda_s, sda_p} <= 3'h7;
			sel_m                 <= 2'h0;
			sel_s                 <= 2'h0;
		end else begin
			{scl_m, scl_s, scl_p} <= {bus.scl, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {bus.sda, sda_m, sda_s};
			sel_m                 <= dev_sel;
			sel_s                 <= sel_m;
		end
	end

	// Byte sequencer; START and STOP override every state.
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			st_q     <= DS_IDLE;
			cnt_q    <= 4'h0;
			ack_q    <= 1'b0;
			sh_q     <= 8'h00;
			tx_q     <= 8'hFF;
			oe_q     <= 1'b0;
			rd_q     <= 1'b0;
			reg_sp_q <= 1'b0;
			maddr_q  <= 15'h0000;
			ahi_q    <= 7'h00;
			raddr_q  <= 8'h00;
		end else if (start_det) begin
			// Abort, keep both address latches, expect a slave address.
			st_q  <= DS_SLAVE; // [RULE_12] [RULE_22]
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			oe_q  <= 1'b0; // [RULE_10]
		end else if (stop_det) begin
			// Abort and release the data line.
			st_q  <= DS_IDLE; // [RULE_22]
			ack_q <= 1'b0;
			oe_q  <= 1'b0; // [RULE_10]
		end else if (st_q == DS_READ) begin
			if (ack_q) begin
				if (scl_rise) begin
					// Keep the master acknowledge bit.
					sh_q[0] <= sda_s;
				end else if (scl_fall) begin
					if (sh_q[0]) begin
						// Master refused: end the read.
						st_q  <= DS_IDLE; // [RULE_09] [RULE_22]
						ack_q <= 1'b0;
					end else begin
						// Master acknowledged: drive the next byte.
						ack_q <= 1'b0; // [RULE_08]
						oe_q  <= !rd_byte[7];
						tx_q  <= {rd_byte[6:0], 1'b1};
						cnt_q <= 4'h1;
					end
				end
			end else if (scl_fall) begin
				if (cnt_q == `I2CMS_ACK_SLOT) begin
					// Byte sent: free the line and step the address.
					oe_q  <= 1'b0;
					ack_q <= 1'b1;
					if (reg_sp_q) begin
						raddr_q <= raddr_q + 8'h01; // [RULE_15] [RULE_16]
					end else begin
						maddr_q <= maddr_q + 15'h0001; // [RULE_08] [RULE_11] [RULE_21]
					end
				end else begin
					// Next bit, most significant first.
					oe_q  <= !tx_q[7];
					tx_q  <= {tx_q[6:0], 1'b1};
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end else if (st_q != DS_IDLE) begin
			if (!ack_q) begin
				if (scl_rise && (cnt_q != `I2CMS_ACK_SLOT)) begin
					// Shift in one bit.
					sh_q  <= wdat;
					cnt_q <= cnt_q + 4'h1;
					if (commit && reg_sp_q) begin
						raddr_q <= raddr_q + 8'h01; // [RULE_13] [RULE_16]
					end else if (commit) begin
						maddr_q <= maddr_q + 15'h0001; // [RULE_02] [RULE_03] [RULE_21]
					end
				end else if (scl_fall && (cnt_q == `I2CMS_ACK_SLOT)) begin
					// Acknowledge or refuse the byte.
					ack_q <= byte_ok;
					oe_q  <= byte_ok;
					if (!byte_ok) begin
						st_q <= DS_IDLE; // [RULE_20] [RULE_22]
					end
					case (st_q)
						DS_SLAVE: begin
							rd_q     <= sh_q[0]; // [RULE_01] [RULE_07]
							reg_sp_q <= (sh_q[7:4] == `I2CMS_REG_ID); // [RULE_18]
						end
						DS_ADDR_HI: ahi_q <= sh_q[6:0];
						DS_ADDR_LO: maddr_q <= {ahi_q, sh_q}; // [RULE_21]
						DS_REG_ADDR: begin
							if (byte_ok) begin
								raddr_q <= sh_q; // [RULE_20]
							end
						end
						default: ;
					endcase
				end
			end else if (scl_fall) begin
				// Acknowledge slot over; a read starts driving at once.
				ack_q <= 1'b0;
				st_q  <= nxt_st;
				if (nxt_st == DS_READ) begin
					oe_q  <= !rd_byte[7]; // [RULE_07]
					tx_q  <= {rd_byte[6:0], 1'b1};
					cnt_q <= 4'h1;
				end else begin
					oe_q  <= 1'b0;
					cnt_q <= 4'h0;
				end
			end
		end
	end

	// Memory array takes each committed byte alone.
	always_ff @(posedge link_clk) begin
		if (commit && !reg_sp_q) begin
			mem[maddr_q] <= wdat; // [RULE_05] [RULE_06] [RULE_18]
		end
	end

	// Register space write strobe, one link cycle per committed byte.
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			wr_stb_q  <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
			sda_o_q   <= 1'b0;
		end else begin
			wr_stb_q  <= commit && reg_sp_q; // [RULE_13]
			wr_addr_q <= raddr_q;
			wr_data_q <= wdat;
			sda_o_q   <= 1'b0;
		end
	end

	// Outputs straight from flip-flops.
	assign bus.s_sda_o  = sda_o_q;
	assign bus.s_sda_oe = oe_q;
	assign reg_wr_stb   = wr_stb_q;
	assign reg_wr_addr  = wr_addr_q;
	assign reg_wr_data  = wr_data_q;
	assign reg_rd_addr  = raddr_q;

endmodule

// ===== core/i2cms_host.sv
// Master end: byte-level START, WRITE, READ and STOP over the two-wire bus.
// Assumes the slave never stretches SCL; SCL comes from a core_clk divider.
`timescale 1ns/100ps
`include "i2cms_defines.svh"

module i2cms_host
	import i2cms_pkg::*;
(
	// Core clock and synchronous reset.
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Two-wire bus.
	i2cms_if.host           bus,
	// Command port.
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire i2cms_op_e  cmd_op,
	input  wire logic [7:0] cmd_data,
	input  wire logic       cmd_ack_n,
	// Response port.
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_nack
);

	// Last core cycle of an SCL quarter period.
	localparam logic [5:0] QTR_LAST = 6'(`I2CMS_SCL_QTR_CYC - 1);

	i2cms_hst_e  st_q;       // Sequencer state.
	logic [5:0]  tick_q;     // Cycles within a quarter.
	logic [1:0]  qtr_q;      // Quarter within a bit.
	logic [3:0]  bit_q;      // Bit within a byte.
	logic [8:0]  tx_q;       // Bits to send, ninth is the ack bit.
	logic [8:0]  rx_q;       // Bits sampled from the line.
	logic        scl_oe_q;   // Master pulls SCL low.
	logic        sda_oe_q;   // Master pulls SDA low.
	logic        pin_lo_q;   // Driven level, always low.
	logic        sda_m;      // SDA first stage.
	logic        sda_s;      // SDA second stage.
	logic        rdy_q;      // Command accepted when high.
	logic        rv_q;       // Response valid pulse.
	logic [7:0]  rd_q;       // Response byte.
	logic        nk_q;       // Response acknowledge bit.
	logic        q_end;      // Last cycle of a quarter.
	logic        take;       // Command taken.

	assign q_end = (st_q != HS_IDLE) && (tick_q == QTR_LAST);
	assign take  = cmd_valid && rdy_q;

	// Two flip-flops on SDA before it is sampled.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sda_m    <= 1'b1;
			sda_s    <= 1'b1;
			pin_lo_q <= 1'b0;
		end else begin
			sda_m    <= bus.sda;
			sda_s    <= sda_m;
			pin_lo_q <= 1'b0;
		end
	end

	// Quarter-period divider that paces SCL.
	always_ff @(posedge core_clk) begin
		if (!rst_n || (st_q == HS_IDLE) || q_end) begin
			tick_q <= 6'h00;
		end else begin
			tick_q <= tick_q + 6'h01;
		end
	end

	// Command sequencer; SCL rises after quarter 0 and, except in STOP, falls after quarter 2.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q     <= HS_IDLE;
			qtr_q    <= 2'h0;
			bit_q    <= 4'h0;
			tx_q     <= 9'h1FF;
			rx_q     <= 9'h000;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rdy_q    <= 1'b1;
			rv_q     <= 1'b0;
			rd_q     <= 8'h00;
			nk_q     <= 1'b0;
		end else begin
			rv_q <= 1'b0;
			if (take) begin
				// Accept a command and set up its first quarter.
				rdy_q <= 1'b0;
				qtr_q <= 2'h0;
				bit_q <= 4'h0;
				case (cmd_op)
					I2CMS_OP_START: begin
						st_q     <= HS_START; // [RULE_12]
						sda_oe_q <= 1'b0;
					end
					I2CMS_OP_STOP: begin
						st_q     <= HS_STOP;
						sda_oe_q <= 1'b1;
					end
					I2CMS_OP_WRITE: begin
						st_q     <= HS_BIT; // [RULE_14] [RULE_17]
						tx_q     <= {cmd_data, 1'b1};
						sda_oe_q <= !cmd_data[7];
					end
					default: begin
						st_q     <= HS_BIT;
						tx_q     <= {8'hFF, cmd_ack_n}; // [RULE_09]
						sda_oe_q <= 1'b0;
					end
				endcase
			end else if (q_end) begin
				qtr_q <= qtr_q + 2'h1;
				case (qtr_q)
					2'h0: scl_oe_q <= 1'b0;
					2'h1: begin
						if (st_q == HS_START) begin
							sda_oe_q <= 1'b1;
						end else if (st_q == HS_STOP) begin
							sda_oe_q <= 1'b0;
						end else begin
							rx_q <= {rx_q[7:0], sda_s};
						end
					end
					2'h2: begin
						if (st_q != HS_STOP) begin
							scl_oe_q <= 1'b1;
						end
					end
					default: begin
						if ((st_q == HS_BIT) && (bit_q != `I2CMS_ACK_SLOT)) begin
							// Present the next bit while SCL is low.
							bit_q    <= bit_q + 4'h1;
							tx_q     <= {tx_q[7:0], 1'b1};
							sda_oe_q <= !tx_q[7];
						end else begin
							st_q  <= HS_IDLE;
							rdy_q <= 1'b1;
							rv_q  <= (st_q == HS_BIT);
							rd_q  <= rx_q[8:1];
							nk_q  <= rx_q[0];
						end
					end
				endcase
			end
		end
	end

	// Outputs straight from flip-flops.
	assign bus.scl_o    = pin_lo_q;
	assign bus.scl_oe   = scl_oe_q;
	assign bus.m_sda_o  = pin_lo_q;
	assign bus.m_sda_oe = sda_oe_q;
	assign cmd_ready    = rdy_q;
	assign rsp_valid    = rv_q;
	assign rsp_data     = rd_q;
	assign rsp_nack     = nk_q;

endmodule

// ===== dv/i2cms_checker.sv
// Checker for the two-wire link between the master end and the slave end.
// Assumes raw resolved lines and slave pins, all sampled on link_clk.
`timescale 1ns/100ps

module i2cms_checker (
	// Link clock and its reset.
	input  wire logic       link_clk,
	input  wire logic       link_rst_n,
	// Resolved lines and the slave drive enable.
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       s_sda_oe,
	// Slave side pins.
	input  wire logic [1:0] dev_sel,
	input  wire logic       reg_wr_stb
);
	logic       scl_q;   // Clock line one cycle ago.
	logic       sda_q;   // Data line one cycle ago.
	logic       selw_q;  // Addressed for a write.
	logic       selr_q;  // Addressed for a read.
	logic       reg_q;   // Register space was addressed.
	logic [3:0] cnt_q;   // Clock rises seen in the current byte.
	logic [1:0] byte_q;  // Byte index after START, saturating.
	logic [7:0] sh_q;    // Bits taken on clock rises.
	wire        rise  = !scl_q && scl;
	wire        start = scl_q && scl && sda_q && !sda;
	wire        stop  = scl_q && scl && !sda_q && sda;
	wire        ack9  = rise && cnt_q == 4'h9 - 4'h1;
	wire        id_ok = (sh_q[7:4] == 4'hA || sh_q[7:4] == 4'hD) && sh_q[2:1] == dev_sel;

	default clocking @(posedge link_clk); endclocking
	default disable iff (!link_rst_n);

	// Follows bit and byte position; reset clears the position and forces the line history high.
	always_ff @(posedge link_clk) begin
		scl_q <= link_rst_n ? scl : 1'b1;
		sda_q <= link_rst_n ? sda : 1'b1;
		if (!link_rst_n || start) begin
			cnt_q  <= 4'h0;
			byte_q <= 2'h0;
			selw_q <= 1'b0;
			selr_q <= 1'b0;
		end else if (rise) begin
			sh_q  <= {sh_q[6:0], sda};
			cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
			if (cnt_q == 4'h9 && byte_q != 2'h3)
				byte_q <= byte_q + 2'h1;
			if (ack9 && byte_q == 2'h0) begin
				selw_q <= id_ok && !sh_q[0];
				selr_q <= id_ok && sh_q[0];
				reg_q  <= sh_q[7:4] == 4'hD;
			end
		end
	end

	property p_slave_ack;
		ack9 && byte_q == 2'h0 |-> sda == !id_ok;
	endproperty
	a_slave_ack: assert property (p_slave_ack) else $error("slave address answer wrong");
	property p_wr_ack;
		ack9 && byte_q != 2'h0 && selw_q && !(reg_q && byte_q == 2'h1 && sh_q > 8'h18) |-> !sda;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write byte not acknowledged");
	property p_reg_nack;
		ack9 && byte_q == 2'h1 && selw_q && reg_q && sh_q > 8'h18 |-> sda;
	endproperty
	a_reg_nack: assert property (p_reg_nack) else $error("bad register address taken");
	property p_rd_rel;
		ack9 && byte_q != 2'h0 && selr_q |-> !s_sda_oe;
	endproperty
	a_rd_rel: assert property (p_rd_rel) else $error("slave drives in read ack slot");
	property p_abort_rel;
		start || stop |-> ##[1:8] !s_sda_oe;
	endproperty
	a_abort_rel: assert property (p_abort_rel) else $error("data line held after abort");
	property p_reg_stb;
		rise && cnt_q == 4'h7 && byte_q > 2'h1 && selw_q && reg_q |-> ##[1:8] reg_wr_stb;
	endproperty
	a_reg_stb: assert property (p_reg_stb) else $error("register write strobe missing");
	property p_oe_edge;
		!$stable(s_sda_oe) |-> !scl;
	endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("slave moved data while clock high");
	property p_ack_hold;
		s_sda_oe && scl |=> s_sda_oe;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("slave level dropped mid clock");
endmodule

// ===== dv/i2cms_bench.sv
// Self-checking bench joining the master end to the slave end.
// Assumes the core/ files are compiled first; registers are modelled here.
`timescale 1ns/100ps

module i2cms_bench;
	import i2cms_pkg::*;
	logic       core_clk, rst_n, link_clk, link_rst_n;  // Clocks and resets.
	logic       cmd_valid, cmd_ack_n, cmd_ready;        // Command handshake.
	logic       rsp_valid, rsp_nack, reg_wr_stb;        // Responses and strobe.
	logic       v_q, nk_q;                              // Last response flags.
	i2cms_op_e  cmd_op;                                 // Command kind.
	logic [7:0] cmd_data, rsp_data, rd_q, d;            // Bytes in flight.
	logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr;  // Register port.
	logic [1:0] dev_sel, s;                             // Select pins and choice.
	logic [3:0] id;                                     // Identifier tried.
	logic [7:0] regs [256];                             // Register space model.
	logic [7:0] mem [32768];                            // Expected memory.
	int         err_count, cmp_count, seed;             // Tallies and seed.

	i2cms_if bus_i ();
	i2cms_host i2cms_host_i (.core_clk, .rst_n, .bus(bus_i), .cmd_valid, .cmd_ready, .cmd_op,
		.cmd_data, .cmd_ack_n, .rsp_valid, .rsp_data, .rsp_nack);
	i2cms_dev i2cms_dev_i (.link_clk, .link_rst_n, .bus(bus_i), .dev_sel, .reg_wr_stb,
		.reg_wr_addr, .reg_wr_data, .reg_rd_addr, .reg_rd_data(regs[reg_rd_addr]));
	i2cms_checker i2cms_checker_i (.link_clk, .link_rst_n, .scl(bus_i.scl), .sda(bus_i.sda),
		.s_sda_oe(bus_i.s_sda_oe), .dev_sel, .reg_wr_stb);

	// Core clock, and a link clock offset so the phases never line up.
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = !core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = !link_clk;
	end

	// The register space stores whatever the slave strobes out.
	always @(posedge link_clk) begin
		if (reg_wr_stb)
			regs[reg_wr_addr] <= reg_wr_data;
	end

	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Counts a comparison and reports a mismatch.
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Hands one command over and waits, bounded, until the master is ready.
	task automatic cmd(i2cms_op_e op, logic [7:0] dat, logic ackn);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_data  <= dat;
		cmd_ack_n <= ackn;
		do begin
			@(posedge core_clk);
			n++;
		end while (!cmd_ready && n < 3000);
		cmd_valid <= 1'b0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!cmd_ready && n < 3000);
		if (n >= 3000) begin
			err_count++;
			$display("CHECK FAILED cmd_ready expected 1 seen 0");
			stop_test();
		end else begin
			rd_q = rsp_data;
			v_q  = rsp_valid;
			nk_q = rsp_nack;
		end
	endtask

	// Writes one byte and checks the answer on the ninth clock.
	task automatic wb(logic [7:0] dat, logic exp_nack);
		cmd(I2CMS_OP_WRITE, dat, 1'b1);
		chk("write answer", {7'h01, exp_nack}, {6'h00, v_q, nk_q});
	endtask

	// Reads one byte, sending ackn back, and checks it.
	task automatic rb(logic [7:0] exp, logic ackn);
		cmd(I2CMS_OP_READ, 8'h00, ackn);
		chk("read data", exp, rd_q);
	endtask

	// Builds a slave address byte; bit 3 is left low.
	function automatic logic [7:0] sa(logic [3:0] ident, logic [1:0] sel, logic rnw);
		return {ident, 1'b0, sel, rnw};
	endfunction

	// Loads an address, turns round with a repeated START and reads n bytes.
	task automatic rd_at(logic [3:0] ident, logic [14:0] a, int n);
		logic [7:0] e;
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		wb(sa(ident, dev_sel, 1'b0), 1'b0);
		if (ident == 4'hA)
			wb({1'b1, a[14:8]}, 1'b0);
		wb(a[7:0], 1'b0);
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		wb(sa(ident, dev_sel, 1'b1), 1'b0);
		for (int i = 0; i < n; i++) begin
			e = (ident == 4'hA) ? mem[15'(a + 15'(i))] : regs[8'(a) + 8'(i)];
			rb(e, i == n - 1);
		end
		cmd(I2CMS_OP_STOP, 8'h00, 1'b1);
	endtask

	// Main sequence.
	initial begin
		seed = 78;
		err_count = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		link_rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = I2CMS_OP_START;
		cmd_data = 8'h00;
		cmd_ack_n = 1'b1;
		dev_sel = 2'h2;
		for (int i = 0; i < 256; i++)
			regs[i] = 8'(i) ^ 8'h3C;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		link_rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		// Four bytes across the top of memory, then an immediate read back.
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		wb(sa(4'hA, dev_sel, 1'b0), 1'b0);
		wb(8'hFF, 1'b0);
		wb(8'hFE, 1'b0);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			mem[15'h7FFE + 15'(i)] = d;
			wb(d, 1'b0);
		end
		cmd(I2CMS_OP_STOP, 8'h00, 1'b1);
		rd_at(4'hA, 15'h7FFE, 3);
		// Two register writes up to the last valid address.
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		wb(sa(4'hD, dev_sel, 1'b0), 1'b0);
		wb(8'h17, 1'b0);
		wb(8'hA5, 1'b0);
		wb(8'h5A, 1'b0);
		cmd(I2CMS_OP_STOP, 8'h00, 1'b1);
		chk("reg 17", 8'hA5, regs[8'h17]);
		chk("reg 18", 8'h5A, regs[8'h18]);
		// A register address past the top is refused.
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		wb(sa(4'hD, dev_sel, 1'b0), 1'b0);
		wb(8'h19, 1'b1);
		cmd(I2CMS_OP_STOP, 8'h00, 1'b1);
		rd_at(4'hD, 15'h0017, 2);
		// Memory resumes where it stopped despite register traffic.
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		wb(sa(4'hA, dev_sel, 1'b1), 1'b0);
		rb(mem[1], 1'b1);
		cmd(I2CMS_OP_STOP, 8'h00, 1'b1);
		// Register current read, ended by a no-acknowledge and a START.
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		wb(sa(4'hD, dev_sel, 1'b1), 1'b0);
		rb(regs[8'h19], 1'b0);
		rb(regs[8'h1A], 1'b1);
		cmd(I2CMS_OP_START, 8'h00, 1'b1);
		cmd(I2CMS_OP_STOP, 8'h00, 1'b1);
		// Identifiers and select pins, matching or not, answered by polls.
		for (int i = 0; i < 8; i++) begin
			dev_sel <= 2'($random(seed));
			@(posedge core_clk);
			id = (i % 4 == 0) ? 4'hA : (i % 4 == 1) ? 4'hD : (i % 4 == 2) ? 4'h5 : 4'hE;
			s = (i < 4) ? dev_sel : 2'($random(seed));
			cmd(I2CMS_OP_START, 8'h00, 1'b1);
			wb(sa(id, s, 1'b0), !((id == 4'hA || id == 4'hD) && s == dev_sel));
			cmd(I2CMS_OP_STOP, 8'h00, 1'b1);
		end
		stop_test();
	end
endmodule
